// *** rtl/mode_select_pin_sharing.sv ***
/*
 * Operation-mode select register, host access front end and shared-pin
 * control (pin 10, pin 13, address bit eleven, float test).
 * Assumes the mode cores sit behind MEM_REQ/MEM_RDATA on the same clock and
 * that pad pull-downs and tri-state buffers are outside this logic.
 */
`timescale 1ns/1ps
module mode_select_pin_sharing
  import mode_select_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  input  wire logic [1:0]  BUS_MODE,
  input  wire logic [9:0]  ADDR_LO,
  input  wire logic        ADDR_BIT_TEN_I,
  output logic             SECOND_INTERRUPT_OUT,
  output logic             PIN10_OE_N,
  input  wire logic        CS_N,
  input  wire logic        LATCH_STROBE_PIN,
  input  wire logic        WRITE_OR_ECLK_PIN,
  input  wire logic        RD_N,
  input  wire logic        WR_N,
  input  wire logic [7:0]  DATA_I,
  output logic      [7:0]  DATA_O,
  output logic             DATA_OE_N,
  output logic             READY_N,
  output logic             READY_OE_N,
  output logic             PIN13_O,
  output logic             PIN13_OE_N,
  input  wire logic        OUTPUTS_FLOAT_TEST_N,
  input  wire logic        TOKEN_HELD,
  input  wire logic        DATA_EXCHANGE,
  input  wire logic        ISO_ENABLE,
  input  wire logic        SYNC_PULSE,
  input  wire logic        RAM_4K,
  input  wire logic [1:0]  SEGMENT,
  input  wire logic        INT2_REQ,
  input  wire logic [7:0]  MEM_RDATA,
  output mem_req_s         MEM_REQ,
  output op_mode_e         OP_MODE,
  output logic             BLOCKS_EN,
  output logic             MAP_VISIBLE
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  localparam int SW = 27;

  // Idle levels: read and write strobes and chip select high, latch and eclk pins low, float test inactive
  localparam logic [SW-1:0] PIN_IDLE = {2'b00, 10'h000, 1'b0, 1'b1, 1'b0, 1'b0,
                                        1'b1, 1'b1, 8'h00, 1'b1};

  logic [SW-1:0] pins_raw;
  logic [SW-1:0] pins_s;
  logic [1:0]    bus_mode_s;
  logic [9:0]    addr_lo_s;
  logic          bit_ten_s;
  logic          cs_n_s;
  logic          latch_s;
  logic          wr_eclk_s;
  logic          rd_n_s;
  logic          wr_n_s;
  logic [7:0]    data_s;
  logic          float_n_s;

  assign pins_raw = {BUS_MODE, ADDR_LO, ADDR_BIT_TEN_I, CS_N, LATCH_STROBE_PIN,
                     WRITE_OR_ECLK_PIN, RD_N, WR_N, DATA_I, OUTPUTS_FLOAT_TEST_N};
  assign {bus_mode_s, addr_lo_s, bit_ten_s, cs_n_s, latch_s,
          wr_eclk_s, rd_n_s, wr_n_s, data_s, float_n_s} = pins_s;

  pin_sync #(
    .WIDTH     (SW)
  ) u_pin_sync (
    .clk       (MCLK),
    .reset_n   (RESET_N),
    .clk_en    (CLK_EN),
    .async_in  (pins_raw),
    .reset_val (PIN_IDLE),
    .sync_out  (pins_s)
  );

  bus_mode_e bus_mode;
  assign bus_mode = bus_mode_e'(bus_mode_s);

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_NONE,
    ST_STARTUP,
    ST_ACTIVE
  } mode_state_e;

  mode_state_e state_reg;
  logic [7:0]  mode_sel_reg;
  logic        rd_n_prev_reg;
  logic        wr_n_prev_reg;
  logic        rd_req;
  logic        wr_req;
  logic        chip_sel;
  logic        bit_ten_in;
  logic        bit_eleven;
  logic [11:0] lin_addr;
  logic [11:0] map_addr;
  logic        mode_valid;
  logic        start_pulse;
  logic        timer_busy;
  logic        timer_done;
  op_mode_e    op_mode_next;

  // Pin 10 is an input only while the multipoint mode is not chosen
  assign bit_ten_in = (OP_MODE == OP_MULTI) ? 1'b0 : bit_ten_s;

  // Host strobes: read taken on the falling edge, write on the rising edge
  assign rd_req = rd_n_prev_reg && !rd_n_s && chip_sel;
  assign wr_req = !wr_n_prev_reg && wr_n_s && chip_sel;

  always_comb begin
    if (bus_mode == BUS_SYNC_A) begin
      chip_sel = (bit_ten_in == CS_MATCH_BIT_TEN);
    end else begin
      chip_sel = !cs_n_s;
    end
  end

  // Twelfth address line for the 4k slave setting depends on the host bus mode
  always_comb begin
    unique case (bus_mode)
      BUS_SYNC_A:  bit_eleven = cs_n_s;
      BUS_ASYNC_B: bit_eleven = wr_eclk_s;
      default:     bit_eleven = latch_s;
    endcase
  end

  assign lin_addr = {2'b00, addr_lo_s};

  always_comb begin
    unique case (OP_MODE)
      OP_MULTI: map_addr = {SEGMENT, addr_lo_s};
      OP_SLAVE: begin
        if (RAM_4K) begin
          map_addr = {bit_eleven, bit_ten_in, addr_lo_s};
        end else begin
          map_addr = {1'b0, bit_ten_in, addr_lo_s};
        end
      end
      default:  map_addr = lin_addr;
    endcase
  end

  always_comb begin
    unique case (data_s)
      MODE_CODE_MULTI:  op_mode_next = OP_MULTI;
      MODE_CODE_SERIAL: op_mode_next = OP_SERIAL;
      MODE_CODE_SLAVE:  op_mode_next = OP_SLAVE;
      default:          op_mode_next = OP_NONE;
    endcase
  end

  assign mode_valid  = (op_mode_next != OP_NONE);
  assign start_pulse = (state_reg == ST_NONE) && wr_req &&
                       (lin_addr == MODE_SELECT_OFFSET) && mode_valid;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      rd_n_prev_reg <= 1'b1;
      wr_n_prev_reg <= 1'b1;
    end else if (CLK_EN) begin
      rd_n_prev_reg <= rd_n_s;
      wr_n_prev_reg <= wr_n_s;
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      state_reg    <= ST_NONE;
      mode_sel_reg <= MODE_SELECT_RESET;
      OP_MODE      <= OP_NONE;
    end else if (CLK_EN) begin
      unique case (state_reg)
        ST_NONE: begin
          // Invalid codes are simply not stored, so the chip stays without mode
          if (start_pulse) begin
            mode_sel_reg <= data_s;
            OP_MODE      <= op_mode_next;
            state_reg    <= ST_STARTUP;
          end
        end
        ST_STARTUP: begin
          if (timer_done) begin
            state_reg <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          // Only a reset leaves this state; the register is no longer decoded
          state_reg <= ST_ACTIVE;
        end
      endcase
    end
  end

  startup_timer #(
    .CYCLES  (STARTUP_CYCLES)
  ) u_startup_timer (
    .clk     (MCLK),
    .reset_n (RESET_N),
    .clk_en  (CLK_EN),
    .start   (start_pulse),
    .busy    (timer_busy),
    .done    (timer_done)
  );

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      BLOCKS_EN   <= 1'b0;
      MAP_VISIBLE <= 1'b0;
    end else if (CLK_EN) begin
      // Done pulse bridges the cycle between the timer and the state change
      BLOCKS_EN   <= timer_busy || timer_done || (state_reg == ST_ACTIVE);
      MAP_VISIBLE <= (state_reg == ST_ACTIVE) || timer_done;
    end
  end

  // ****************************************************************
  // Memory map forwarding
  // ****************************************************************
  // Accesses in the start-up window are dropped; the host keeps off the bus
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      MEM_REQ <= '0;
    end else if (CLK_EN) begin
      MEM_REQ.wr    <= wr_req && (state_reg == ST_ACTIVE);
      MEM_REQ.rd    <= rd_req && (state_reg == ST_ACTIVE);
      MEM_REQ.addr  <= map_addr;
      MEM_REQ.wdata <= data_s;
    end
  end

  // ****************************************************************
  // Host read data and ready
  // ****************************************************************
  logic read_open;

  assign read_open = !rd_n_s && chip_sel;

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      DATA_O    <= 8'h00;
      DATA_OE_N <= 1'b1;
    end else if (CLK_EN) begin
      // Without a mode the data is meaningless; the register value is shown
      DATA_O    <= (state_reg == ST_ACTIVE) ? MEM_RDATA : mode_sel_reg;
      DATA_OE_N <= !(read_open && float_n_s);
    end
  end

  // Ready is given in every state so the host never stalls
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      READY_N    <= 1'b1;
      READY_OE_N <= 1'b1;
    end else if (CLK_EN) begin
      if (rd_req || wr_req) begin
        READY_N <= 1'b0;
      end else if (rd_n_s) begin
        READY_N <= 1'b1;
      end
      READY_OE_N <= !float_n_s;
    end
  end

  // ****************************************************************
  // Shared pins 10 and 13
  // ****************************************************************
  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      SECOND_INTERRUPT_OUT <= 1'b0;
      PIN10_OE_N           <= 1'b1;
    end else if (CLK_EN) begin
      SECOND_INTERRUPT_OUT <= (OP_MODE == OP_MULTI) && INT2_REQ;
      // Drive starts with the mode write itself, not after start-up
      PIN10_OE_N <= !(((OP_MODE == OP_MULTI) ||
                       (start_pulse && op_mode_next == OP_MULTI)) && float_n_s);
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      PIN13_O    <= 1'b1;
      PIN13_OE_N <= 1'b1;
    end else if (CLK_EN) begin
      unique case (OP_MODE)
        OP_MULTI: PIN13_O <= !TOKEN_HELD;
        OP_SLAVE: PIN13_O <= ISO_ENABLE ? SYNC_PULSE : !DATA_EXCHANGE;
        default:  PIN13_O <= 1'b1;
      endcase
      PIN13_OE_N <= !float_n_s;
    end
  end

endmodule // mode_select_pin_sharing

// *** rtl/mode_select_pkg.sv ***
/*
 * Holds the constants, mode codes, host bus modes and carrier struct of the
 * operation-mode select and shared-pin block.
 * Assumes a 100 MHz system clock and a host on the parallel address/data bus.
 */
package mode_select_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS     = 10;
  localparam int STARTUP_CYCLES    = 10;
  localparam int HOST_QUIET_NS     = 200;
  localparam int HOST_QUIET_CYCLES = (HOST_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ****************************************************************
  // Register map and codes
  // ****************************************************************
  localparam logic [11:0] MODE_SELECT_OFFSET = 12'h000;
  localparam logic [7:0]  MODE_SELECT_RESET  = 8'h00;
  localparam logic [7:0]  MODE_CODE_NONE     = 8'h00;
  localparam logic [7:0]  MODE_CODE_MULTI    = 8'h01;
  localparam logic [7:0]  MODE_CODE_SERIAL   = 8'h02;
  localparam logic [7:0]  MODE_CODE_SLAVE    = 8'h03;

  // Level of address bit ten that selects the chip in synchronous mode A
  localparam logic        CS_MATCH_BIT_TEN   = 1'b0;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    BUS_SYNC_A,
    BUS_ASYNC_A,
    BUS_ASYNC_B,
    BUS_SYNC_B
  } bus_mode_e;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_MULTI,
    OP_SERIAL,
    OP_SLAVE
  } op_mode_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } mem_req_s;

endpackage

// *** rtl/pin_sync.sv ***
/*
 * Two-flop synchroniser for a vector of pin inputs.
 * Assumes every bit is independent; multi-bit values must be stable while read.
 */
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_val,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage is read only by the second stage
  // Both stages reset to the idle pin levels so no false strobe edge follows reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      meta_reg <= reset_val;
      sync_out <= reset_val;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // pin_sync

// *** rtl/startup_timer.sv ***
/*
 * Counts the block-enable period after a mode has been chosen.
 * Assumes start is a one-cycle pulse; a start while busy is ignored.
 */
`timescale 1ns/1ps
module startup_timer
  import mode_select_pkg::*;
#(
  parameter int CYCLES = STARTUP_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      busy,
  output logic      done
);

  localparam int CW = $clog2(CYCLES + 1);

  logic [CW-1:0] count_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      count_reg <= '0;
      busy      <= 1'b0;
      done      <= 1'b0;
    end else if (clk_en) begin
      done <= 1'b0;
      if (start && !busy) begin
        busy      <= 1'b1;
        count_reg <= CW'(CYCLES - 1);
      end else if (busy) begin
        if (count_reg == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - 1'b1;
        end
      end
    end
  end

endmodule // startup_timer

// *** tb/host_bus_model.sv ***
/* Host processor model on the parallel address/data bus.
   Assumes one clock shared with the bench, which calls its tasks. */
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic       clk,
  input  wire logic [1:0] bus_mode,
  input  wire logic       ready_n,
  input  wire logic       ready_oe_n,
  input  wire logic [7:0] rdata,
  output logic      [9:0] addr_lo,
  output logic            bit_ten,
  output logic            drive_ten,
  output logic            cs_n,
  output logic            strobe_pin,
  output logic            eclk_pin,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] wdata
);
  initial begin
    {addr_lo, bit_ten, strobe_pin, eclk_pin, wdata} = '0;
    {cs_n, rd_n, wr_n, drive_ten} = 4'hf;
  end

  // switches the host drive of address bit ten on pin 10 on or off
  task automatic set_ten_drive(input logic en);
    drive_ten = en;
  endtask

  // Bit eleven rides the pin of the bus mode; eclk gets the inverse, except in bus mode 2 where strobe does
  task automatic access(input logic wr, input logic [11:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic ok);
    int n;
    addr_lo = a[9:0];
    bit_ten = a[10];
    cs_n = (bus_mode == 2'd0) ? a[11] : 1'b0;
    strobe_pin = (bus_mode == 2'd2) ? ~a[11] : a[11];
    eclk_pin = (bus_mode == 2'd2) ? a[11] : ~a[11];
    wdata = d;
    n = 0;
    ok = 1'b0;
    if (wr) begin
      wr_n = 1'b0;
      repeat (3) @(posedge clk);
      #1 wr_n = 1'b1;
    end else begin
      rd_n = 1'b0;
    end
    while (!ok && n < 12) begin
      @(posedge clk);
      ok = !ready_n && !ready_oe_n;
      n++;
    end
    q = rdata;
    #1 rd_n = 1'b1;
    cs_n = 1'b1;
    wdata = ~d; // Released data lines must not keep a stale value
    repeat (3) @(posedge clk);
    #1;
  endtask
endmodule // host_bus_model

// *** tb/mode_select_pin_sharing_chk.sv ***
/* Concurrent checks on the ports of the mode select and pin sharing block.
   Assumes one MCLK domain and the synchronous active-low reset. */
`timescale 1ns/1ps
module mode_select_pin_sharing_chk
  import mode_select_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RESET_N,
  input wire logic [1:0] BUS_MODE,
  input wire logic       ADDR_BIT_TEN_I,
  input wire logic       CS_N,
  input wire logic       RD_N,
  input wire logic       WR_N,
  input wire logic       OUTPUTS_FLOAT_TEST_N,
  input wire logic       TOKEN_HELD,
  input wire logic       DATA_EXCHANGE,
  input wire logic       ISO_ENABLE,
  input wire logic       SYNC_PULSE,
  input op_mode_e        OP_MODE,
  input wire logic       BLOCKS_EN,
  input wire logic       MAP_VISIBLE,
  input wire logic       PIN10_OE_N,
  input wire logic       DATA_OE_N,
  input wire logic       READY_N,
  input wire logic       READY_OE_N,
  input wire logic       PIN13_O,
  input wire logic       PIN13_OE_N
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RESET_N);

  // ****
  // Sequences
  // ****
  sequence float_held;
    !OUTPUTS_FLOAT_TEST_N [*4];
  endsequence
  sequence startup_wait;
    !MAP_VISIBLE [*8] ##1 !MAP_VISIBLE [*2] ##1 MAP_VISIBLE;
  endsequence

  // ****
  // Assertions
  // ****
  chk_reset_none: assert property ($rose(RESET_N) |-> OP_MODE == OP_NONE && !MAP_VISIBLE)
    else $error("mode not cleared by reset");
  chk_mode_locked: assert property (OP_MODE != OP_NONE |=> $stable(OP_MODE))
    else $error("selected mode changed");
  chk_only_from_none: assert property ($changed(OP_MODE) |-> $past(OP_MODE) == OP_NONE)
    else $error("mode changed outside no-mode state");
  chk_startup_len: assert property ($rose(BLOCKS_EN) |-> startup_wait)
    else $error("memory map shown at wrong time");
  chk_pin10_input: assert property (OP_MODE != OP_MULTI |-> PIN10_OE_N)
    else $error("pin 10 driven outside multipoint mode");
  chk_pin10_output: assert property ((OP_MODE == OP_MULTI && OUTPUTS_FLOAT_TEST_N) [*4]
    |-> !PIN10_OE_N) else $error("pin 10 not driven in multipoint mode");
  chk_pin13_idle: assert property (OP_MODE == OP_NONE |-> PIN13_O)
    else $error("pin 13 active without mode");
  chk_pin13_token: assert property (OP_MODE == OP_MULTI && $past(OP_MODE) == OP_MULTI
    |-> PIN13_O == !$past(TOKEN_HELD)) else $error("pin 13 does not follow token");
  chk_pin13_slave: assert property (OP_MODE == OP_SLAVE && $past(OP_MODE) == OP_SLAVE
    |-> PIN13_O == ($past(ISO_ENABLE) ? $past(SYNC_PULSE) : !$past(DATA_EXCHANGE)))
    else $error("pin 13 wrong in slave mode");
  chk_float_all: assert property (float_held
    |-> PIN10_OE_N && DATA_OE_N && READY_OE_N && PIN13_OE_N) else $error("pin driven in float test");
  chk_write_ready: assert property ($rose(WR_N) && !CS_N && BUS_MODE != BUS_SYNC_A
    |-> ##[3:5] !READY_N && !READY_OE_N) else $error("no ready after write");
  chk_sel_bit_ten: assert property ($fell(RD_N) && BUS_MODE == BUS_SYNC_A && ADDR_BIT_TEN_I
    && OP_MODE == OP_NONE |-> (READY_N || READY_OE_N) [*6]) else $error("unselected read answered");
endmodule // mode_select_pin_sharing_chk

bind mode_select_pin_sharing mode_select_pin_sharing_chk u_chk (
  .MCLK, .RESET_N, .BUS_MODE, .ADDR_BIT_TEN_I, .CS_N, .RD_N, .WR_N, .OUTPUTS_FLOAT_TEST_N,
  .TOKEN_HELD, .DATA_EXCHANGE, .ISO_ENABLE, .SYNC_PULSE, .OP_MODE, .BLOCKS_EN, .MAP_VISIBLE,
  .PIN10_OE_N, .DATA_OE_N, .READY_N, .READY_OE_N, .PIN13_O, .PIN13_OE_N);

// *** tb/test_mode_select_pin_sharing.sv ***
/* Self-checking bench for the mode select and pin sharing block.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ps
module test_mode_select_pin_sharing;
  import mode_select_pkg::*;
  logic       mclk, reset_n, float_n, token, dx, iso, sync, ram4k, int2, ok;
  logic       ten, drive_ten, ten_wire, cs_n, strobe, eclk, rd_n, wr_n, pin10_o;
  logic       pin10_oe_n, data_oe_n, ready_n, ready_oe_n, pin13, pin13_oe_n, blocks_en, map_vis;
  logic [1:0] bus_mode, seg, m;
  logic [7:0] mem_rdata, q, wdata, data_o, code;
  logic [9:0] addr_lo;
  logic [11:0] a;
  logic [31:0] r;
  mem_req_s   mem_req, last_req;
  op_mode_e   op_mode;
  int         err_count, checked, cycles, seed;

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Pin 10 wire: device drive, else host, else the pad pull-down
  assign ten_wire = !pin10_oe_n ? pin10_o : (drive_ten ? ten : 1'b0);
  always @(posedge mclk) begin
    cycles++;
    if (mem_req.wr) last_req <= mem_req;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end

  mode_select_pin_sharing u_dut (.MCLK(mclk), .RESET_N(reset_n), .CLK_EN(1'b1),
    .BUS_MODE(bus_mode), .ADDR_LO(addr_lo), .ADDR_BIT_TEN_I(ten_wire),
    .SECOND_INTERRUPT_OUT(pin10_o), .PIN10_OE_N(pin10_oe_n), .CS_N(cs_n),
    .LATCH_STROBE_PIN(strobe), .WRITE_OR_ECLK_PIN(eclk), .RD_N(rd_n), .WR_N(wr_n),
    .DATA_I(wdata), .DATA_O(data_o), .DATA_OE_N(data_oe_n), .READY_N(ready_n),
    .READY_OE_N(ready_oe_n), .PIN13_O(pin13), .PIN13_OE_N(pin13_oe_n),
    .OUTPUTS_FLOAT_TEST_N(float_n), .TOKEN_HELD(token), .DATA_EXCHANGE(dx), .ISO_ENABLE(iso),
    .SYNC_PULSE(sync), .RAM_4K(ram4k), .SEGMENT(seg), .INT2_REQ(int2), .MEM_RDATA(mem_rdata),
    .MEM_REQ(mem_req), .OP_MODE(op_mode), .BLOCKS_EN(blocks_en), .MAP_VISIBLE(map_vis));
  host_bus_model u_host (.clk(mclk), .bus_mode(bus_mode), .ready_n(ready_n),
    .ready_oe_n(ready_oe_n), .rdata(data_o), .addr_lo(addr_lo), .bit_ten(ten),
    .drive_ten(drive_ten), .cs_n(cs_n), .strobe_pin(strobe), .eclk_pin(eclk), .rd_n(rd_n),
    .wr_n(wr_n), .wdata(wdata));

  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  function automatic logic pin13_of(input logic [1:0] md);
    case (md)
      2'd1: return !token;
      2'd3: return iso ? sync : !dx;
      default: return 1'b1;
    endcase
  endfunction
  function automatic logic [11:0] addr_of(input logic [1:0] md, input logic [11:0] ad);
    if (md == 2'd1) return {seg, ad[9:0]};
    return ram4k ? ad : {1'b0, ad[10:0]};
  endfunction

  // ****
  // Main sequence: one reset and mode write per pass; slave code in all four bus modes, multipoint in 0 and 1, serial in 2, invalid in 3
  // ****
  initial begin
    seed = 32'h9d47a6e4;
    {reset_n, token, dx, iso, sync, ram4k, int2, seg, mem_rdata, bus_mode} = '0;
    float_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      code = (i < 4) ? 8'h03 : (i < 6) ? 8'h01 : (i == 6) ? 8'h02 : (r[7:0] | 8'h04);
      m = (code inside {8'h01, 8'h02, 8'h03}) ? code[1:0] : 2'd0;
      reset_n = 1'b0;
      bus_mode = i[1:0];
      u_host.set_ten_drive(1'b1);
      step(20);
      reset_n = 1'b1;
      step(2);
      u_host.access(1'b0, 12'h000, 8'h00, q, ok);
      check("ready without mode", ok, 1);
      check("read data", q, MODE_SELECT_RESET);
      if (i == 4) begin
        u_host.access(1'b0, 12'h400, 8'h00, q, ok);
        check("unselected read", ok, 0);
      end
      if (m == 2'd1) u_host.set_ten_drive(1'b0);
      u_host.access(1'b1, 12'h000, code, q, ok);
      step(20);
      check("mode", op_mode, m);
      check("map visible", map_vis, m != 2'd0);
      last_req = '1;
      u_host.access(1'b1, 12'h000, code ^ 8'h02, q, ok);
      check("mode kept", op_mode, m);
      if (m[0]) check("write redirected", last_req.addr, addr_of(m, 12'h000));
      repeat (6) begin
        r = $random(seed);
        {token, dx, iso, sync, int2, seg, ram4k, mem_rdata} = r[15:0];
        step(3);
        check("pin 13", pin13, pin13_of(m));
        if (m == 2'd1) check("pin 10 out", ten_wire, int2);
        if (m[0]) begin
          int2 = 1'b0;
          a = r[27:16];
          if (i[1:0] == 2'd0) a[10] = 1'b0;
          last_req = '1;
          u_host.access(1'b1, a, r[7:0], q, ok);
          check("memory address", last_req.addr, addr_of(m, a));
          check("memory data", last_req.wdata, r[7:0]);
        end
      end
      float_n = 1'b0;
      step(4);
      check("float", {pin10_oe_n, data_oe_n, ready_oe_n, pin13_oe_n}, 4'hf);
      float_n = 1'b1;
      $display("test %0d code %h done", i, code);
    end
    print_verdict();
  end
endmodule // test_mode_select_pin_sharing
